// [logic/xor_skip_pkg.sv]
// Constants shared by the table-write, test-skip and XOR executor
`default_nettype none
package xor_skip_pkg;
	// Widths
	localparam int ADDR_W = 8;
	localparam int TPTR_W = 21;
	localparam int HOLD_N = 8;
	localparam int FADDR_W = 12;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_WORK = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_TPTR = 8'h0C;
	localparam logic [7:0] OFS_TLAT = 8'h10;
	localparam logic [7:0] OFS_BANK = 8'h14;
	localparam logic [7:0] OFS_EXEC = 8'h18;
	// Holding registers sit at 0x20 + 4*index
	localparam logic [2:0] HOLD_PAGE = 3'h1;
	// Field positions
	localparam int CTRL_RUN_BIT = 0;
	localparam int STAT_Z_BIT = 0;
	localparam int STAT_N_BIT = 1;
	localparam int EXEC_BUSY_BIT = 0;
	localparam int EXEC_BAD_BIT = 1;
	// Reset values
	localparam logic [7:0] WORK_RST = 8'h00;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [TPTR_W-1:0] TPTR_RST = 21'h000000;
	localparam logic [3:0] BANK_RST = 4'h0;
	localparam logic [7:0] HOLD_RST = 8'hFF;
	// Opcode patterns
	localparam logic [13:0] OP_TSTORE_HI = 14'h0003;
	localparam logic [3:0] OP_TST_HI = 4'h6;
	localparam logic [2:0] OP_TST_MID = 3'h3;
	localparam logic [7:0] OP_XORL_HI = 8'h0A;
	localparam logic [5:0] OP_XORF_HI = 6'h06;
	// Table pointer modes
	localparam logic [1:0] TM_NONE = 2'h0;
	localparam logic [1:0] TM_POST_INC = 2'h1;
	localparam logic [1:0] TM_POST_DEC = 2'h2;
	localparam logic [1:0] TM_PRE_INC = 2'h3;
	// Quarter-cycle phases
	localparam logic [1:0] Q1 = 2'h0;
	localparam logic [1:0] Q2 = 2'h1;
	localparam logic [1:0] Q3 = 2'h2;
	localparam logic [1:0] Q4 = 2'h3;
	// Access bank split: low half bank 0, high half top bank
	localparam logic [7:0] ACCESS_SPLIT = 8'h80;
	localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
	// Executor states
	typedef enum logic [1:0] {IDLE, EXEC, STALL} exec_state_t;
endpackage : xor_skip_pkg
`default_nettype wire

// [logic/xor_skip_exec.sv]
// Executor for table write, test-skip-if-zero and the two XOR instructions
`default_nettype none
module xor_skip_exec
	import xor_skip_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [xor_skip_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Fetch side
	input wire logic instr_valid,
	input wire logic [15:0] instr_word,
	input wire logic next_is_two_word,
	output logic instr_ready,
	output logic flush_next,
	// Data memory side
	output logic [xor_skip_pkg::FADDR_W-1:0] file_addr,
	output logic file_rd,
	input wire logic [7:0] file_rdata,
	output logic file_wr,
	output logic [7:0] file_wdata
);
	import xor_skip_pkg::*;

	// Bank mapping for file accesses
	function automatic logic [FADDR_W-1:0] bank_addr(input logic a, input logic [7:0] f,
		input logic [3:0] sel_bank);
		logic [3:0] bank;
		bank = (f < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK;
		if (a)
		begin
			bank = sel_bank;
		end
		return {bank, f};
	endfunction : bank_addr

	// Programmer-visible state
	logic run; // Executor may take instructions
	logic [7:0] wreg; // Working register
	logic flag_z; // Zero flag
	logic flag_n; // Negative flag
	logic [TPTR_W-1:0] table_pointer; // Byte pointer into program memory
	logic [7:0] table_latch; // Byte to store
	logic [3:0] bank_select_reg; // Bank for a=1 accesses
	logic bad_op; // Sticky: unknown opcode seen
	logic [7:0] hold [HOLD_N]; // Program-memory write holding registers

	// Sequencer state
	logic [1:0] qph; // Quarter phase, free running
	exec_state_t state;
	exec_state_t next_state;
	logic [15:0] ir; // Instruction in execution
	logic two_word; // Follower is a two-word instruction
	logic [1:0] stall_cnt; // NOP cycles still to run
	logic [7:0] opnd; // File operand caught in Q2

	// APB decode
	wire setup = psel & ~penable;
	wire wr_en = psel & penable & pwrite & pready;
	wire wr_ctrl = wr_en & (paddr == OFS_CTRL);
	wire wr_work = wr_en & (paddr == OFS_WORK);
	wire wr_status = wr_en & (paddr == OFS_STATUS);
	wire wr_tptr = wr_en & (paddr == OFS_TPTR);
	wire wr_tlat = wr_en & (paddr == OFS_TLAT);
	wire wr_bank = wr_en & (paddr == OFS_BANK);
	wire wr_exec = wr_en & (paddr == OFS_EXEC);
	wire hold_hit = (paddr[7:5] == HOLD_PAGE) & (paddr[1:0] == 2'h0);

	// Instruction decode
	// table write opcode
	wire is_table_store = (ir[15:2] == OP_TSTORE_HI);
	wire is_tst = (ir[15:12] == OP_TST_HI) & (ir[7:5] == OP_TST_MID);
	wire is_xorl = (ir[15:8] == OP_XORL_HI);
	wire is_xorf = (ir[15:10] == OP_XORF_HI);
	wire [1:0] tmode = ir[1:0];
	wire [7:0] tst_f = {ir[11:8], ir[3:0]};
	wire bank_a = is_tst ? ir[4] : ir[8];
	wire [7:0] file_f = is_tst ? tst_f : ir[7:0];
	wire dest_file = ir[9];
	wire known_op = is_table_store | is_tst | is_xorl | is_xorf;

	// Shared XOR datapath, literal or file operand
	wire [7:0] xor_res = wreg ^ (is_xorl ? ir[7:0] : opnd);
	wire is_xor = is_xorl | is_xorf;
	wire skip = is_tst & (opnd == 8'h00);

	// NOP cycles after the first: table write one, skip one or two
	wire [1:0] extra = is_table_store ? 2'h1 : (skip ? (two_word ? 2'h2 : 2'h1) : 2'h0);
	wire phase_end = (qph == Q4);
	wire take = phase_end & instr_ready & instr_valid;
	wire last_cycle = (state == IDLE) | ((state == EXEC) & (extra == 2'h0))
		| ((state == STALL) & (stall_cnt == 2'h1));

	// Register read mux
	logic [31:0] rd_word;
	logic rd_ok;
	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_ok = 1'b1;
		unique case (paddr)
			OFS_CTRL: rd_word[CTRL_RUN_BIT] = run;
			OFS_WORK: rd_word[7:0] = wreg;
			OFS_STATUS:
			begin
				rd_word[STAT_Z_BIT] = flag_z;
				rd_word[STAT_N_BIT] = flag_n;
			end
			OFS_TPTR: rd_word[TPTR_W-1:0] = table_pointer;
			OFS_TLAT: rd_word[7:0] = table_latch;
			OFS_BANK: rd_word[3:0] = bank_select_reg;
			OFS_EXEC:
			begin
				rd_word[EXEC_BUSY_BIT] = (state != IDLE);
				rd_word[EXEC_BAD_BIT] = bad_op;
				rd_word[3:2] = stall_cnt;
			end
			default:
			begin
				rd_ok = hold_hit;
				rd_word[7:0] = hold_hit ? hold[paddr[4:2]] : 8'h00;
			end
		endcase
	end

	// APB answer: zero wait, read data registered in setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup & ~rd_ok;
			prdata <= setup ? rd_word : 32'h0000_0000;
		end
	end

	// Sequencer next state
	always_comb
	begin
		next_state = state;
		unique case (state)
			IDLE: if (take) next_state = EXEC;
			EXEC:
				if (phase_end)
				begin
					if (extra != 2'h0) next_state = STALL;
					else next_state = take ? EXEC : IDLE;
				end
			STALL:
				if (phase_end && stall_cnt == 2'h1)
				begin
					next_state = take ? EXEC : IDLE;
				end
		endcase
	end

	// Phase counter, state, instruction register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			qph <= Q1;
			state <= IDLE;
			ir <= 16'h0000;
			two_word <= 1'b0;
			stall_cnt <= 2'h0;
			instr_ready <= 1'b0;
		end
		else
		begin
			qph <= qph + 2'h1;
			state <= next_state;
			if (take)
			begin
				ir <= instr_word;
				two_word <= next_is_two_word;
			end
			if (state == EXEC && phase_end) stall_cnt <= extra;
			else if (state == STALL && phase_end) stall_cnt <= stall_cnt - 2'h1;
			// Ready only in Q4 of a finishing cycle, so fetch stays in step
			instr_ready <= run & (qph == Q3) & last_cycle;
		end
	end

	// Data memory strobes and flush
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			file_addr <= 12'h000;
			file_rd <= 1'b0;
			file_wr <= 1'b0;
			file_wdata <= 8'h00;
			flush_next <= 1'b0;
			opnd <= 8'h00;
		end
		else
		begin
			if (state == EXEC && qph == Q1)
			begin
				file_addr <= bank_addr(bank_a, file_f, bank_select_reg);
			end
			// Read strobe stands through Q2
			file_rd <= (state == EXEC) & (qph == Q1) & (is_tst | is_xorf);
			if (file_rd) opnd <= file_rdata;
			file_wr <= (state == EXEC) & (qph == Q3) & is_xorf & dest_file;
			if (state == EXEC && qph == Q3) file_wdata <= xor_res;
			flush_next <= (state == EXEC) & (qph == Q3) & skip;
		end
	end

	// W, flags and software control
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			run <= 1'b0;
			wreg <= WORK_RST;
			flag_z <= 1'b0;
			flag_n <= 1'b0;
			bank_select_reg <= BANK_RST;
			bad_op <= 1'b0;
		end
		else
		begin
			if (wr_ctrl) run <= pwdata[CTRL_RUN_BIT];
			if (wr_bank) bank_select_reg <= pwdata[3:0];
			// Core write beats a software write in the same cycle
			// W written at Q4
			if (state == EXEC && phase_end && (is_xorl || (is_xorf && !dest_file)))
				wreg <= xor_res;
			else if (wr_work)
				wreg <= pwdata[7:0];
			if (state == EXEC && phase_end && is_xor)
			begin
				flag_z <= (xor_res == 8'h00);
				flag_n <= xor_res[7];
			end
			else if (wr_status)
			begin
				flag_z <= pwdata[STAT_Z_BIT];
				flag_n <= pwdata[STAT_N_BIT];
			end
			// Unknown opcode runs as a NOP; set beats clear
			if (state == EXEC && qph == Q1 && !known_op) bad_op <= 1'b1;
			else if (wr_exec && pwdata[EXEC_BAD_BIT]) bad_op <= 1'b0;
		end
	end

	// Table pointer, latch and holding registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			table_pointer <= TPTR_RST;
			table_latch <= BYTE_RST;
			for (int i = 0; i < HOLD_N; i++) hold[i] <= HOLD_RST;
		end
		else
		begin
			if (wr_tlat) table_latch <= pwdata[7:0];
			// pointer is a 21-bit byte address
			if (state == EXEC && phase_end && is_table_store && tmode == TM_PRE_INC)
				table_pointer <= table_pointer + 21'h1;
			else if (state == STALL && phase_end && is_table_store && tmode == TM_POST_INC)
				table_pointer <= table_pointer + 21'h1;
			else if (state == STALL && phase_end && is_table_store && tmode == TM_POST_DEC)
				table_pointer <= table_pointer - 21'h1;
			else if (wr_tptr)
				table_pointer <= pwdata[TPTR_W-1:0];
			// low pointer bits select holding register
			if (state == STALL && phase_end && is_table_store)
				hold[table_pointer[2:0]] <= table_latch;
		end
	end

	// Checks
	sequence skip_seen(logic tw);
		(state == EXEC) && (qph == Q3) && skip && (two_word == tw);
	endsequence

	a_xorl_wreg_update: assert property (@(posedge pclk) disable iff (!presetn)
		(state == EXEC && phase_end && is_xorl)
		|=> wreg == ($past(wreg) ^ $past(ir[7:0])))
		else $error("XOR literal result wrong in W");

	a_xor_nz_flags: assert property (@(posedge pclk) disable iff (!presetn)
		(state == EXEC && phase_end && is_xor)
		|=> flag_z == ($past(xor_res) == 8'h00) && flag_n == $past(xor_res[7]))
		else $error("XOR flags do not match result");

	a_tst_flags_kept: assert property (@(posedge pclk) disable iff (!presetn)
		(state == EXEC && phase_end && (is_tst || is_table_store) && !wr_status)
		|=> $stable({flag_z, flag_n}))
		else $error("Flags changed by non-XOR op");

	a_skip_one_nop: assert property (@(posedge pclk) disable iff (!presetn)
		skip_seen(1'b0) |=> flush_next ##1 (state == STALL) [*4] ##1 (state != STALL))
		else $error("Skip did not add one NOP cycle");

	a_skip_two_nops: assert property (@(posedge pclk) disable iff (!presetn)
		skip_seen(1'b1) |-> ##2 (state == STALL) [*8] ##1 (state != STALL))
		else $error("Skip over two-word op not two NOPs");

	a_noskip_no_stall: assert property (@(posedge pclk) disable iff (!presetn)
		(state == EXEC && qph == Q3 && is_tst && !skip) |-> ##2 state != STALL)
		else $error("Non-zero test stalled");

	a_hold_write: assert property (@(posedge pclk) disable iff (!presetn)
		(state == STALL && phase_end && is_table_store)
		|=> hold[$past(table_pointer[2:0])] == $past(table_latch))
		else $error("Holding register not loaded");

	a_post_inc_ptr: assert property (@(posedge pclk) disable iff (!presetn)
		(state == EXEC && phase_end && is_table_store && tmode == TM_POST_INC)
		|=> (table_pointer == $past(table_pointer)) ##4 (table_pointer == $past(table_pointer, 5) + 21'h1))
		else $error("Post-increment pointer wrong");

	a_access_bank: assert property (@(posedge pclk) disable iff (!presetn)
		(file_rd && !bank_a)
		|-> file_addr[11:8] == (file_addr[7] ? ACCESS_HIGH_BANK : ACCESS_LOW_BANK))
		else $error("Access bank not used for a=0");

	a_xorf_file_dest: assert property (@(posedge pclk) disable iff (!presetn)
		(state == EXEC && qph == Q3 && is_xorf && dest_file)
		|=> file_wr && file_wdata == $past(xor_res) ##1 !file_wr)
		else $error("XOR file result not written in Q4");
endmodule : xor_skip_exec
`default_nettype wire

// [testbench/data_mem_model.sv]
// Data memory model answering the executor's file port
`default_nettype none
module data_mem_model
	import xor_skip_pkg::*;
(
	// Clock
	input wire logic pclk,
	// File port
	input wire logic [xor_skip_pkg::FADDR_W-1:0] file_addr,
	input wire logic file_rd,
	output logic [7:0] file_rdata,
	input wire logic file_wr,
	input wire logic [7:0] file_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// Byte array, preloaded by the bench
	logic [7:0] mem [0:4095];
	// Toggles so an idle read port never looks valid
	logic tog = 1'b0;
	// Data only while the read strobe is up
	assign file_rdata = file_rd ? mem[file_addr] : {8{tog}};
	// Write on the strobe edge
	always @(posedge pclk)
	begin
		tog <= ~tog;
		if (file_wr)
			mem[file_addr] <= file_wdata;
	end
endmodule : data_mem_model
`default_nettype wire

// [testbench/table_write_skip_xor_exec_tb.sv]
// Self-checking bench for the table write, test-skip and XOR executor
`default_nettype none
module table_write_skip_xor_exec_tb;
	import xor_skip_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	// Bench-driven inputs
	logic pclk, presetn, psel, penable, pwrite, instr_valid, next_is_two_word;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [15:0] instr_word;
	// Design outputs
	logic [31:0] prdata;
	logic pready, pslverr, instr_ready, flush_next, file_rd, file_wr;
	logic [FADDR_W-1:0] file_addr;
	logic [7:0] file_rdata, file_wdata;
	// Bookkeeping
	int n_fail = 0;
	int comparisons = 0;
	logic [31:0] q;
	logic perr;
	int n, fl, m;
	logic [20:0] p, e;
	xor_skip_exec dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .instr_valid(instr_valid), .instr_word(instr_word),
		.next_is_two_word(next_is_two_word), .instr_ready(instr_ready),
		.flush_next(flush_next), .file_addr(file_addr), .file_rd(file_rd),
		.file_rdata(file_rdata), .file_wr(file_wr), .file_wdata(file_wdata));
	data_mem_model mem_u (.pclk(pclk), .file_addr(file_addr), .file_rd(file_rd),
		.file_rdata(file_rdata), .file_wr(file_wr), .file_wdata(file_wdata));
	// 50 ns clock
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// Verdict and stop
	task automatic end_of_test;
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test
	// Value compare, four-state exact
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// One APB transfer, then an idle cycle so strobes are never reassigned at once
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20)
		begin
			n_fail++;
			end_of_test();
		end
		q = prdata;
		perr = pslverr;
		{psel, penable} <= 2'b00;
		@(posedge pclk);
	endtask : apb
	// Offer one instruction, count clocks to the next take point and flushes seen
	task automatic run_op(input logic [15:0] w, input logic two);
		int i;
		{instr_valid, instr_word, next_is_two_word} <= {1'b1, w, two};
		for (i = 0; i < 40; i++)
		begin
			@(posedge pclk);
			if (instr_ready === 1'b1)
				break;
		end
		instr_valid <= 1'b0;
		n = 0;
		fl = 0;
		for (i = i; i < 80; i++)
		begin
			@(posedge pclk);
			n++;
			fl += (flush_next === 1'b1);
			if (instr_ready === 1'b1)
				break;
		end
		if (i >= 80)
		begin
			n_fail++;
			end_of_test();
		end
	endtask : run_op
	// Main sequence
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{instr_valid, instr_word, next_is_two_word} = '0;
		presetn = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Reset values and an unmapped address
		apb(1'b0, OFS_WORK, 32'h0);
		chk(q, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		chk(q, 32'hFF);
		apb(1'b0, 8'h1C, 32'h0);
		chk({q[31:1], perr}, 32'h1);
		apb(1'b1, OFS_CTRL, 32'h1);
		apb(1'b1, OFS_WORK, 32'hB5);
		// XOR literal, nonzero then zero result
		run_op(16'h0AAF, 1'b0);
		chk(n, 4);
		apb(1'b0, OFS_WORK, 32'h0);
		chk(q, 32'h1A);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(q, 32'h0);
		run_op(16'h0A1A, 1'b0);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(q, 32'h1);
		// XOR file into file, access bank low half
		apb(1'b1, OFS_WORK, 32'hB5);
		apb(1'b1, OFS_BANK, 32'h2);
		mem_u.mem[12'h010] = 8'hAF;
		mem_u.mem[12'h220] = 8'h4A;
		mem_u.mem[12'hF90] = 8'hFF;
		run_op(16'h1A10, 1'b0);
		// Model stores on the same edge that ends the op; let it settle
		@(posedge pclk);
		chk(mem_u.mem[12'h010], 32'h1A);
		apb(1'b0, OFS_WORK, 32'h0);
		chk(q, 32'hB5);
		// XOR file into W through the bank select
		run_op(16'h1920, 1'b0);
		apb(1'b0, OFS_WORK, 32'h0);
		chk(q, 32'hFF);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(q, 32'h2);
		// Access bank high half overrides the bank select
		run_op(16'h1890, 1'b0);
		apb(1'b0, OFS_WORK, 32'h0);
		chk(q, 32'h0);
		// Test-skip: zero, zero before a two-word op, nonzero in bank 2
		mem_u.mem[12'h035] = 8'h00;
		mem_u.mem[12'h235] = 8'h07;
		run_op(16'h6365, 1'b0);
		chk({n[15:0], fl[15:0]}, {16'd8, 16'd1});
		run_op(16'h6365, 1'b1);
		chk({n[15:0], fl[15:0]}, {16'd12, 16'd1});
		run_op(16'h6375, 1'b0);
		chk({n[15:0], fl[15:0]}, {16'd4, 16'd0});
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(q, 32'h1);
		// Table write in all four pointer modes
		for (m = 0; m < 4; m++)
		begin
			p = 21'h00A354 + 21'(2 * m);
			e = (m == 3) ? p + 21'h1 : p;
			apb(1'b1, OFS_TPTR, {11'h0, p});
			apb(1'b1, OFS_TLAT, 32'h50 + m);
			run_op(16'h000C | 16'(m), 1'b0);
			chk(n, 8);
			apb(1'b0, 8'h20 + {3'h0, e[2:0], 2'h0}, 32'h0);
			chk(q, 32'h50 + m);
			apb(1'b0, OFS_TPTR, 32'h0);
			chk(q, {11'h0, (m == 0) ? p : (m == 2) ? p - 21'h1 : p + 21'h1});
		end
		// Unknown opcode runs as a NOP and is flagged
		run_op(16'hFFFF, 1'b0);
		chk(n, 4);
		apb(1'b0, OFS_EXEC, 32'h0);
		chk(q, 32'h2);
		// Writing one clears the sticky opcode flag
		apb(1'b1, OFS_EXEC, 32'h2);
		apb(1'b0, OFS_EXEC, 32'h0);
		chk(q, 32'h0);
		end_of_test();
	end
endmodule : table_write_skip_xor_exec_tb
`default_nettype wire
